// >>> rtl/event_wait_irq_control.sv
// Per-core event wait, interrupt channel and breakpoint control unit
//
// Operation
// - wait stalls core until chosen event flag sets, then clears it; two clocks minimum
// - queue load right before a wait gives a system counter timeout deadline
// - wait with carry or zero option writes that flag high on timeout
// - each of three channels takes a 4-bit source code from operand low bits
// - force instruction raises its channel interrupt even while interrupts are held
// - break inside debug routine loads operand as next break condition
// - break outside debug stores low byte code and raises break interrupt if enabled
// - cross-core break from debug routine hits core numbered by operand low nibble
// - break status read returns status selected by carry/zero option; two clocks
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
module event_wait_irq_control (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   // Instruction side
   input wire logic instr_valid,
   input wire logic [3:0] instr_op,
   input wire logic [31:0] instr_arg,
   input wire logic [3:0] instr_sel,
   input wire logic [1:0] instr_chan,
   input wire logic instr_wc,
   input wire logic instr_wz,
   input wire logic debug_isr,
   output logic instr_ready,
   output logic instr_done,
   output logic [31:0] result_data,
   output logic result_c,
   output logic result_z,
   output logic result_c_we,
   output logic result_z_we,
   // Event and interrupt side
   input wire logic [15:0] event_in,
   input wire logic [2:0] irq_ack,
   output logic [2:0] irq_req,
   input wire logic break_ack,
   output logic break_req,
   input wire logic async_break_in,
   output logic [15:0] cross_break_out,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_WAIT
   } state_t;

   typedef struct packed {
      state_t st;
      logic ready;
      logic [31:0] count;
      logic [31:0] queue;
      logic queue_fresh;
      logic [31:0] deadline;
      logic tmo_armed;
      logic [3:0] wait_sel;
      logic wait_wc;
      logic wait_wz;
      logic done;
      logic [31:0] res_data;
      logic res_c;
      logic res_z;
      logic res_c_we;
      logic res_z_we;
      logic hold;
      logic [2:0][3:0] src;
      logic [2:0] pend;
      logic [2:0] forced;
      logic [2:0] irq_req;
      logic [7:0] brk_code;
      logic [31:0] brk_cond;
      logic brk_pend;
      logic [15:0] xbrk;
      logic [1:0] ctrl;
      logic [2:0] irq_en;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } core_t;

   core_t cur_ff;
   core_t nxt_cur;
   logic [15:0] ev_flags_ff;
   logic [15:0] ev_set;
   logic [15:0] ev_clr;
   logic [2:0] irq_stat_ff;
   logic [2:0] irq_set;
   logic [2:0] irq_clr;

   // ==========================================================
   // Helpers
   function automatic logic [15:0] one_hot(input logic [3:0] idx);
      one_hot = 16'h0001 << idx;
   endfunction

   // Wrap-safe compare: deadline reached once the difference turns non-negative
   function automatic logic reached(input logic [31:0] now, input logic [31:0] dl);
      logic [31:0] diff;
      diff = now - dl;
      reached = ~diff[31];
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == event_wait_irq_control_pkg::REG_CTRL) ||
                (a == event_wait_irq_control_pkg::REG_STATUS) ||
                (a == event_wait_irq_control_pkg::REG_IRQ_STAT) ||
                (a == event_wait_irq_control_pkg::REG_IRQ_CLR) ||
                (a == event_wait_irq_control_pkg::REG_IRQ_EN) ||
                (a == event_wait_irq_control_pkg::REG_COUNT) ||
                (a == event_wait_irq_control_pkg::REG_BREAK);
   endfunction

   // ==========================================================
   // Sticky flag banks
   sticky_flag_bank #(
      .WIDTH(event_wait_irq_control_pkg::EV_W)
   ) u_event_flags (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .set_mask(ev_set),
      .clr_mask(ev_clr),
      .flags_ff(ev_flags_ff)
   );

   sticky_flag_bank #(
      .WIDTH(event_wait_irq_control_pkg::IRQ_W)
   ) u_irq_status (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .set_mask(irq_set),
      .clr_mask(irq_clr),
      .flags_ff(irq_stat_ff)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      logic take;
      logic wait_hit;
      logic wait_tmo;
      logic [15:0] ev_now;
      take = 1'b0;
      wait_hit = 1'b0;
      wait_tmo = 1'b0;
      ev_now = 16'h0000;
      nxt_cur = cur_ff;
      ev_set = event_in;
      ev_clr = 16'h0000;
      irq_set = 3'h0;
      irq_clr = 3'h0;
      nxt_cur.count = cur_ff.count + 32'h0000_0001;
      nxt_cur.done = 1'b0;
      nxt_cur.res_c_we = 1'b0;
      nxt_cur.res_z_we = 1'b0;
      nxt_cur.xbrk = 16'h0000;
      nxt_cur.pready = 1'b0;
      nxt_cur.pslverr = 1'b0;

      // Interrupt channels: source event, acknowledge, INT flag
      ev_now = event_in;
      for (int i = 0; i < event_wait_irq_control_pkg::CH_N; i++)
      begin
         // Acknowledge first so a source event in the same cycle is kept
         if (irq_ack[i])
         begin
            nxt_cur.pend[i] = 1'b0;
            nxt_cur.forced[i] = 1'b0;
         end
         if (cur_ff.src[i] != event_wait_irq_control_pkg::EV_OFF && ev_now[cur_ff.src[i]])
            nxt_cur.pend[i] = 1'b1;
      end
      if (|irq_ack)
         ev_set[event_wait_irq_control_pkg::EV_IRQ] = 1'b1;
      if (break_ack)
         nxt_cur.brk_pend = 1'b0;

      // Inbound cross-core breakpoint needs local enable
      if (async_break_in && cur_ff.ctrl[event_wait_irq_control_pkg::CTRL_ASYNC_EN])
      begin
         nxt_cur.brk_pend = 1'b1;
         irq_set[event_wait_irq_control_pkg::IRQ_ASYNC] = 1'b1;
      end

      unique case (cur_ff.st)
         ST_IDLE:
         begin
            take = instr_valid && cur_ff.ready;
         end
         ST_EXEC:
         begin
            nxt_cur.done = 1'b1;
            nxt_cur.ready = 1'b1;
            nxt_cur.st = ST_IDLE;
         end
         ST_WAIT:
         begin
            wait_hit = ev_flags_ff[cur_ff.wait_sel];
            wait_tmo = cur_ff.tmo_armed && reached(cur_ff.count, cur_ff.deadline);
            if (wait_hit || wait_tmo)
            begin
               // Event wins when both land together
               if (wait_hit)
                  ev_clr = one_hot(cur_ff.wait_sel);
               else
                  irq_set[event_wait_irq_control_pkg::IRQ_TIMEOUT] = 1'b1;
               nxt_cur.res_c = ~wait_hit;
               nxt_cur.res_z = ~wait_hit;
               nxt_cur.res_c_we = cur_ff.wait_wc;
               nxt_cur.res_z_we = cur_ff.wait_wz;
               nxt_cur.done = 1'b1;
               nxt_cur.ready = 1'b1;
               nxt_cur.st = ST_IDLE;
            end
         end
      endcase

      if (take)
      begin
         nxt_cur.ready = 1'b0;
         nxt_cur.st = ST_EXEC;
         nxt_cur.queue_fresh = 1'b0;
         unique case (event_wait_irq_control_pkg::op_t'(instr_op))
            event_wait_irq_control_pkg::OP_WAIT:
            begin
               nxt_cur.st = ST_WAIT;
               nxt_cur.wait_sel = instr_sel;
               nxt_cur.wait_wc = instr_wc;
               nxt_cur.wait_wz = instr_wz;
               nxt_cur.tmo_armed = cur_ff.queue_fresh;
               nxt_cur.deadline = cur_ff.queue;
            end
            event_wait_irq_control_pkg::OP_QUEUE_LOAD:
            begin
               nxt_cur.queue = instr_arg;
               nxt_cur.queue_fresh = 1'b1;
            end
            event_wait_irq_control_pkg::OP_IRQ_ALLOW:
               nxt_cur.hold = 1'b0;
            event_wait_irq_control_pkg::OP_IRQ_HOLD:
               nxt_cur.hold = 1'b1;
            event_wait_irq_control_pkg::OP_IRQ_SOURCE:
               nxt_cur.src[instr_chan] = instr_arg[3:0];
            event_wait_irq_control_pkg::OP_IRQ_CANCEL:
            begin
               nxt_cur.pend[instr_chan] = 1'b0;
               nxt_cur.forced[instr_chan] = 1'b0;
            end
            event_wait_irq_control_pkg::OP_IRQ_FORCE:
            begin
               nxt_cur.pend[instr_chan] = 1'b1;
               nxt_cur.forced[instr_chan] = 1'b1;
            end
            event_wait_irq_control_pkg::OP_BREAK:
            begin
               if (debug_isr)
                  nxt_cur.brk_cond = instr_arg;
               else
               begin
                  nxt_cur.brk_code = instr_arg[7:0];
                  if (cur_ff.ctrl[event_wait_irq_control_pkg::CTRL_BRK_EN])
                  begin
                     nxt_cur.brk_pend = 1'b1;
                     irq_set[event_wait_irq_control_pkg::IRQ_BREAK] = 1'b1;
                  end
               end
            end
            event_wait_irq_control_pkg::OP_CROSS_BREAK:
            begin
               // Ignored outside the debug routine
               if (debug_isr)
                  nxt_cur.xbrk = one_hot(instr_arg[3:0]);
            end
            event_wait_irq_control_pkg::OP_BREAK_STATUS:
            begin
               nxt_cur.res_c = cur_ff.brk_pend;
               nxt_cur.res_z = cur_ff.hold;
               nxt_cur.res_c_we = instr_wc;
               nxt_cur.res_z_we = instr_wz;
               if (instr_wc && instr_wz)
                  nxt_cur.res_data = {cur_ff.count[15:0], 13'h0000, cur_ff.hold, debug_isr,
                                      cur_ff.brk_pend};
               else if (instr_wz)
                  nxt_cur.res_data = cur_ff.brk_cond;
               else
                  nxt_cur.res_data = {16'h0000, cur_ff.brk_code, 5'h00, cur_ff.pend};
            end
            default:
            begin
            end
         endcase
      end

      // Held interrupts stay pending; forced ones pass
      for (int i = 0; i < event_wait_irq_control_pkg::CH_N; i++)
         nxt_cur.irq_req[i] = nxt_cur.pend[i] && (~nxt_cur.hold || nxt_cur.forced[i]);

      // ==========================================================
      // APB: zero-wait, data latched in setup, answer in access
      if (psel && !penable)
      begin
         nxt_cur.pready = 1'b1;
         nxt_cur.pslverr = ~addr_ok(paddr);
         nxt_cur.prdata = event_wait_irq_control_pkg::RST_WORD;
         if (!pwrite)
         begin
            unique case (paddr)
               event_wait_irq_control_pkg::REG_CTRL:
                  nxt_cur.prdata = {30'h0000_0000, cur_ff.ctrl};
               event_wait_irq_control_pkg::REG_STATUS:
               begin
                  nxt_cur.prdata[event_wait_irq_control_pkg::STAT_BUSY] = ~cur_ff.ready;
                  nxt_cur.prdata[event_wait_irq_control_pkg::STAT_HOLD] = cur_ff.hold;
                  nxt_cur.prdata[event_wait_irq_control_pkg::STAT_BRK_PEND] = cur_ff.brk_pend;
                  nxt_cur.prdata[event_wait_irq_control_pkg::STAT_PEND_LSB +: 3] = cur_ff.pend;
                  nxt_cur.prdata[event_wait_irq_control_pkg::STAT_CODE_LSB +: 8] =
                     cur_ff.brk_code;
               end
               event_wait_irq_control_pkg::REG_IRQ_STAT:
                  nxt_cur.prdata = {29'h0000_0000, irq_stat_ff};
               event_wait_irq_control_pkg::REG_IRQ_EN:
                  nxt_cur.prdata = {29'h0000_0000, cur_ff.irq_en};
               event_wait_irq_control_pkg::REG_COUNT:
                  nxt_cur.prdata = cur_ff.count;
               event_wait_irq_control_pkg::REG_BREAK:
                  nxt_cur.prdata = cur_ff.brk_cond;
               default:
                  nxt_cur.prdata = event_wait_irq_control_pkg::RST_WORD;
            endcase
         end
      end
      if (psel && penable && cur_ff.pready && pwrite)
      begin
         unique case (paddr)
            event_wait_irq_control_pkg::REG_CTRL:
               nxt_cur.ctrl = pwdata[1:0];
            event_wait_irq_control_pkg::REG_IRQ_CLR:
               irq_clr = pwdata[2:0];
            event_wait_irq_control_pkg::REG_IRQ_EN:
               nxt_cur.irq_en = pwdata[2:0];
            default:
            begin
            end
         endcase
      end
      nxt_cur.irq = |(irq_stat_ff & cur_ff.irq_en);
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cur_ff <= '0;
         cur_ff.st <= ST_IDLE;
         cur_ff.ready <= 1'b1;
         cur_ff.hold <= 1'b0;
         cur_ff.ctrl <= event_wait_irq_control_pkg::RST_CTRL;
         cur_ff.irq_en <= event_wait_irq_control_pkg::RST_IRQ_EN;
      end
      else if (ce)
         cur_ff <= nxt_cur;
   end

   assign instr_ready = cur_ff.ready;
   assign instr_done = cur_ff.done;
   assign result_data = cur_ff.res_data;
   assign result_c = cur_ff.res_c;
   assign result_z = cur_ff.res_z;
   assign result_c_we = cur_ff.res_c_we;
   assign result_z_we = cur_ff.res_z_we;
   assign irq_req = cur_ff.irq_req;
   assign break_req = cur_ff.brk_pend;
   assign cross_break_out = cur_ff.xbrk;
   assign prdata = cur_ff.prdata;
   assign pready = cur_ff.pready;
   assign pslverr = cur_ff.pslverr;
   assign irq = cur_ff.irq;

endmodule // event_wait_irq_control

// >>> rtl/event_wait_irq_control_pkg.sv
// Shared constants, opcodes and register map of the event wait and interrupt control unit
package event_wait_irq_control_pkg;

   // ==========================================================
   // Widths
   localparam int EV_W = 16;
   localparam int EV_SEL_W = 4;
   localparam int CH_N = 3;
   localparam int CORE_N = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CODE_W = 8;
   localparam int IRQ_W = 3;

   // ==========================================================
   // Event flag indices; code zero as interrupt source means off
   localparam logic [3:0] EV_OFF = 4'h0;
   localparam logic [3:0] EV_COUNTER_ONE = 4'h1;
   localparam logic [3:0] EV_COUNTER_TWO = 4'h2;
   localparam logic [3:0] EV_COUNTER_MATCH_THREE = 4'h3;
   localparam logic [3:0] EV_SEL_EVENT_ONE = 4'h4;
   localparam logic [3:0] EV_SEL_EVENT_FOUR = 4'h7;
   localparam logic [3:0] EV_PIN_MATCH_FLAG = 4'h8;
   localparam logic [3:0] EV_HUB_FIFO_BLOCK_WRAP = 4'h9;
   localparam logic [3:0] EV_STREAM_FIFO_IN = 4'hA;
   localparam logic [3:0] EV_STREAM_CMD_DONE = 4'hB;
   localparam logic [3:0] EV_STREAM_LUT_END = 4'hC;
   localparam logic [3:0] EV_STREAM_ROLLOVER = 4'hD;
   localparam logic [3:0] EV_ATTENTION = 4'hE;
   localparam logic [3:0] EV_IRQ = 4'hF;

   // ==========================================================
   // Instructions issued by the core pipeline
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_WAIT = 4'h1,
      OP_QUEUE_LOAD = 4'h2,
      OP_IRQ_ALLOW = 4'h3,
      OP_IRQ_HOLD = 4'h4,
      OP_IRQ_SOURCE = 4'h5,
      OP_IRQ_CANCEL = 4'h6,
      OP_IRQ_FORCE = 4'h7,
      OP_BREAK = 4'h8,
      OP_CROSS_BREAK = 4'h9,
      OP_BREAK_STATUS = 4'hA
   } op_t;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
   localparam logic [7:0] REG_IRQ_EN = 8'h10;
   localparam logic [7:0] REG_COUNT = 8'h14;
   localparam logic [7:0] REG_BREAK = 8'h18;

   // Control fields
   localparam int CTRL_BRK_EN = 0;
   localparam int CTRL_ASYNC_EN = 1;

   // Interrupt status fields
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_BREAK = 1;
   localparam int IRQ_ASYNC = 2;

   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_HOLD = 1;
   localparam int STAT_BRK_PEND = 2;
   localparam int STAT_PEND_LSB = 4;
   localparam int STAT_CODE_LSB = 8;

   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [2:0] RST_IRQ_EN = 3'h0;

endpackage

// >>> rtl/sticky_flag_bank.sv
// Bank of sticky flags where a set in the same cycle beats a clear
`timescale 1ns/10ps
module sticky_flag_bank #(
   parameter int WIDTH = 16
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] set_mask,
   input wire logic [WIDTH-1:0] clr_mask,
   output logic [WIDTH-1:0] flags_ff
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bank_t;

   bank_t cur_ff;
   bank_t nxt_cur;

   always_comb
   begin
      nxt_cur = cur_ff;
      // Set wins so an event landing on the clear edge is kept
      nxt_cur.flags = (cur_ff.flags & ~clr_mask) | set_mask;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         cur_ff <= '0;
      else if (ce)
         cur_ff <= nxt_cur;
   end

   assign flags_ff = cur_ff.flags;

endmodule // sticky_flag_bank

// >>> test/event_wait_irq_control_monitor.sv
// Port-level checker for the event wait and interrupt control unit
`timescale 1ns/10ps
module ewic_port_checker (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [3:0] instr_op,
   input wire logic [31:0] instr_arg,
   input wire logic [1:0] instr_chan,
   input wire logic instr_wc,
   input wire logic instr_wz,
   input wire logic debug_isr,
   input wire logic instr_ready,
   input wire logic instr_done,
   input wire logic result_c_we,
   input wire logic result_z_we,
   input wire logic [2:0] irq_req,
   input wire logic [15:0] cross_break_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready
);
   logic take;
   logic [3:0] op_h, tgt_h;
   logic [1:0] ch_h;
   logic wc_h, wz_h;
   assign take = instr_valid && instr_ready;
   // ==========================================
   // Fields of the last taken instruction
   always_ff @(posedge mclk)
   begin
      if (take)
      begin
         op_h <= instr_op;
         tgt_h <= instr_arg[3:0];
         ch_h <= instr_chan;
         wc_h <= instr_wc;
         wz_h <= instr_wz;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst || !ce);
   sequence s_take(logic [3:0] op);
      take && instr_op == op;
   endsequence
   a_plain_done: assert property (take && instr_op != event_wait_irq_control_pkg::OP_WAIT
      |-> ##2 instr_done) else $error("instruction did not end in two clocks");
   a_wait_min: assert property (s_take(event_wait_irq_control_pkg::OP_WAIT) |=> !instr_done)
      else $error("wait ended too early");
   a_ready_busy: assert property (take |=> !instr_ready || instr_done)
      else $error("ready high while busy");
   a_flag_we: assert property (instr_done && op_h == event_wait_irq_control_pkg::OP_WAIT
      |-> result_c_we == wc_h && result_z_we == wz_h) else $error("flag write wrong");
   a_cross_hit: assert property (s_take(event_wait_irq_control_pkg::OP_CROSS_BREAK) ##0 debug_isr
      |-> ##[1:2] cross_break_out == (16'h0001 << tgt_h)) else $error("cross break miss");
   a_cross_quiet: assert property (s_take(event_wait_irq_control_pkg::OP_CROSS_BREAK) ##0
      !debug_isr |=> (cross_break_out == 16'h0000) [*2]) else $error("cross break leak");
   a_cross_onehot: assert property ($onehot0(cross_break_out))
      else $error("cross break not one-hot");
   a_force_req: assert property (s_take(event_wait_irq_control_pkg::OP_IRQ_FORCE)
      |-> ##[1:2] irq_req[ch_h]) else $error("forced interrupt not raised");
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
endmodule // ewic_port_checker

bind event_wait_irq_control ewic_port_checker ewic_port_checker_i (.mclk, .sys_rst, .ce,
   .instr_valid, .instr_op, .instr_arg, .instr_chan, .instr_wc, .instr_wz, .debug_isr,
   .instr_ready, .instr_done, .result_c_we, .result_z_we, .irq_req, .cross_break_out,
   .psel, .penable, .pready);

// >>> test/core_pipe_model.sv
// Behavioural core pipeline that enters interrupt and break routines
`timescale 1ns/10ps
module core_pipe_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic slow,
   input wire logic [2:0] irq_req,
   input wire logic break_req,
   output logic [2:0] irq_ack,
   output logic break_ack
);
   logic [3:0] req;
   logic [3:0] ack;
   logic [4:0] cnt [4];
   assign req = {break_req, irq_req};
   assign irq_ack = ack[2:0];
   assign break_ack = ack[3];
   // Entry only after a request stood for the pipeline latency
   always_ff @(posedge mclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         ack[i] <= 1'b0;
         if (sys_rst || !req[i] || ack[i])
            cnt[i] <= 5'h00;
         else if (cnt[i] == (slow ? 5'h0C : 5'h03))
            ack[i] <= 1'b1;
         else
            cnt[i] <= cnt[i] + 5'h01;
      end
   end
endmodule // core_pipe_model

// >>> test/test_event_wait_irq_control.sv
// Self-checking bench for the event wait and interrupt control unit
`timescale 1ns/10ps
module test_event_wait_irq_control;
   logic mclk, sys_rst, ce, instr_valid, instr_wc, instr_wz, debug_isr, slow, err;
   logic psel, penable, pwrite, pready, pslverr, irq, async_break_in, break_ack, break_req;
   logic instr_ready, instr_done, result_c, result_z, result_c_we, result_z_we;
   logic [1:0] instr_chan;
   logic [2:0] irq_ack, irq_req;
   logic [3:0] instr_op, instr_sel;
   logic [7:0] paddr;
   logic [15:0] event_in, cross_break_out;
   logic [31:0] instr_arg, pwdata, prdata, result_data, rd, cnt;
   int n_errors, check_count, lat, cyc;
   event_wait_irq_control event_wait_irq_control_i (.mclk, .sys_rst, .ce, .instr_valid,
      .instr_op, .instr_arg, .instr_sel, .instr_chan, .instr_wc, .instr_wz, .debug_isr,
      .instr_ready, .instr_done, .result_data, .result_c, .result_z, .result_c_we,
      .result_z_we, .event_in, .irq_ack, .irq_req, .break_ack, .break_req, .async_break_in,
      .cross_break_out, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq);
   core_pipe_model core_pipe_model_i (.mclk, .sys_rst, .slow, .irq_req, .break_req,
      .irq_ack, .break_ack);
   // ==========================================
   // Clock, timeout and verdict
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // Access tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Flags f are debug, carry write, zero write; s is event index or channel
   task automatic run(input logic [3:0] op, input logic [31:0] arg, input logic [3:0] s,
      input logic [2:0] f);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_op <= op;
      instr_arg <= arg;
      instr_sel <= s;
      instr_chan <= s[1:0];
      {debug_isr, instr_wc, instr_wz} <= f;
      @(posedge mclk);
      instr_valid <= 1'b0;
      lat = 0;
      do
      begin
         @(posedge mclk);
         #1 lat++;
      end
      while (instr_done !== 1'b1);
   endtask
   task automatic ev(input int s);
      @(posedge mclk);
      event_in <= 16'h0001 << s;
      @(posedge mclk);
      event_in <= 16'h0000;
   endtask
   // ==========================================
   // Scenarios
   initial
   begin
      {sys_rst, ce, slow} = 3'b110;
      {instr_valid, instr_wc, instr_wz, debug_isr, psel, penable, pwrite} = 7'h00;
      {instr_op, instr_sel, instr_chan, paddr, async_break_in} = 19'h00000;
      {event_in, instr_arg, pwdata} = 80'h0;
      {n_errors, check_count, cyc} = 0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 chk("ready", 1, instr_ready);
      apb(0, 8'h00, 0);
      chk("ctrl", 0, rd);
      apb(0, 8'h04, 0);
      chk("status", 0, rd);
      apb(0, 8'hFC, 0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      for (int s = 1; s < 16; s++)
      begin
         ev(s);
         run(event_wait_irq_control_pkg::OP_WAIT, 0, s, 3'b010);
         chk("wait cycles", 1, lat);
         chk("wait flags", 32'h2, {result_c_we, result_c});
      end
      apb(0, 8'h14, 0);
      cnt = rd;
      run(event_wait_irq_control_pkg::OP_QUEUE_LOAD, cnt + 40, 0, 0);
      run(event_wait_irq_control_pkg::OP_WAIT, 0, 9, 3'b011);
      chk("timeout flags", 3, {result_c, result_z});
      chk("timeout late", 1, lat > 20);
      apb(0, 8'h08, 0);
      chk("timeout stat", 1, rd);
      apb(1, 8'h10, 7);
      repeat (2) @(posedge mclk);
      #1 chk("irq", 1, irq);
      apb(1, 8'h0C, 1);
      repeat (2) @(posedge mclk);
      #1 chk("irq clr", 0, irq);
      run(event_wait_irq_control_pkg::OP_QUEUE_LOAD, cnt, 0, 0);
      run(event_wait_irq_control_pkg::OP_NOP, 0, 0, 0);
      fork
         run(event_wait_irq_control_pkg::OP_WAIT, 0, 5, 3'b010);
         begin
            repeat (30) @(posedge mclk);
            ev(5);
         end
      join
      chk("disarmed", 32'h2, {lat > 25, result_c});
      for (int c = 0; c < 3; c++)
      begin
         slow = (c == 0);
         run(event_wait_irq_control_pkg::OP_IRQ_SOURCE, 4 + c, c, 0);
         run(event_wait_irq_control_pkg::OP_IRQ_HOLD, 0, 0, 0);
         ev(4 + c);
         repeat (4) @(posedge mclk);
         #1 chk("held req", 0, irq_req);
         apb(0, 8'h04, 0);
         chk("held pend", 32'h2 | (32'h10 << c), rd);
         run(event_wait_irq_control_pkg::OP_IRQ_CANCEL, 0, c, 0);
         apb(0, 8'h04, 0);
         chk("cancelled", 32'h2, rd);
         run(event_wait_irq_control_pkg::OP_IRQ_FORCE, 0, c, 0);
         @(posedge mclk);
         #1 chk("forced", 3'b001 << c, irq_req);
         repeat (20) @(posedge mclk);
         run(event_wait_irq_control_pkg::OP_IRQ_ALLOW, 0, 0, 0);
         ev(4 + c);
         repeat (20) @(posedge mclk);
         #1 chk("entered", 0, irq_req);
         run(event_wait_irq_control_pkg::OP_WAIT, 0, 15, 3'b010);
         chk("entry event", 0, result_c);
      end
      apb(1, 8'h00, 3);
      slow = 1'b1;
      run(event_wait_irq_control_pkg::OP_BREAK, 32'h0000_01A5, 0, 0);
      @(posedge mclk);
      #1 chk("break req", 1, break_req);
      apb(0, 8'h08, 0);
      chk("break stat", 2, rd);
      apb(0, 8'h04, 0);
      chk("break code", 32'h0000_A500, rd & 32'h0000_FF00);
      run(event_wait_irq_control_pkg::OP_BREAK_STATUS, 0, 0, 3'b010);
      chk("status code", 32'h0000_A500, result_data);
      chk("status cycles", 1, lat);
      apb(1, 8'h0C, 7);
      run(event_wait_irq_control_pkg::OP_BREAK, 32'h1234_5678, 0, 3'b100);
      apb(0, 8'h18, 0);
      chk("condition", 32'h1234_5678, rd);
      apb(0, 8'h08, 0);
      chk("no break", 0, rd);
      run(event_wait_irq_control_pkg::OP_BREAK_STATUS, 0, 0, 3'b101);
      chk("status cond", 32'h1234_5678, result_data);
      run(event_wait_irq_control_pkg::OP_CROSS_BREAK, 5, 0, 3'b100);
      run(event_wait_irq_control_pkg::OP_CROSS_BREAK, 6, 0, 3'b000);
      @(posedge mclk);
      async_break_in <= 1'b1;
      @(posedge mclk);
      async_break_in <= 1'b0;
      apb(0, 8'h08, 0);
      chk("async", 4, rd);
      give_verdict();
   end
endmodule // test_event_wait_irq_control
